// file: verilog/tcb_timer.sv
// Operation
// - Output channel 1: polarity 0 drives active high, 1 active low.
// - Input channel 1: polarity 0 captures rising, uninverted; 1 falling, inverted.
// - Output channel 1: enable 0 keeps output inactive, 1 drives pin.
// - Input channel 1: enable 1 allows counter capture, 0 blocks it.
// - Enable 0: channel output held at 0, output enable low.
// - Enable 1 in output direction: output is reference xor polarity, output enable high.
// - Channels 2 to 4 match channel 1, bits 5/4, 9/8, 13/12.
// - Counter advances at input clock divided by prescaler plus one.
// - Prescaler is preload, copied only at update events incl. software and trigger.
// - Counter stays stopped while auto-reload value is zero.
// - Input channel capture register holds last capture, ignores software writes.
// - Channel direction field writable only while its enable bit is 0.
`timescale 1ns/1ps
`default_nettype none
module tcb_timer #(
  parameter int unsigned CNT_W = tcb_pkg::CNT_W
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [tcb_pkg::ADR_W-1:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic [3:0] SEL_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic [tcb_pkg::NUM_CH-1:0] CH_REF,
  input wire logic [tcb_pkg::NUM_CH-1:0] CH_IN,
  input wire logic TRC_IN,
  input wire logic TRIG_RESET,
  output logic [tcb_pkg::NUM_CH-1:0] CH_OUT,
  output logic [tcb_pkg::NUM_CH-1:0] CH_OE,
  output logic [tcb_pkg::NUM_CH-1:0] CH_TRIG,
  output logic UPDATE_EVT
);
  localparam int unsigned NCH = tcb_pkg::NUM_CH;

  if (CNT_W < 2 || CNT_W > 16) begin : g_chk
    $error("tcb_timer: CNT_W must lie between 2 and 16");
  end

  // The direction word holds two bits for each of exactly four channels
  if (NCH != 4) begin : g_chk_ch
    $error("tcb_timer: the register map serves exactly four channels");
  end

  logic ack_r;
  logic [31:0] dat_r;
  logic [31:0] ccer_r;
  logic [7:0] dir_r;
  logic [CNT_W-1:0] cnt_r;
  logic [15:0] psc_r;
  logic [31:0] arr_r;
  logic [CNT_W-1:0] cap_r [NCH];
  logic upd_r;
  logic [31:0] rd_data;
  logic req;
  logic wr;
  logic [7:0] adr;
  logic ug_hit;
  logic sw_clear;
  logic run;
  logic ovf;
  logic upd;
  logic [31:0] cnt_wide;
  logic [CNT_W-1:0] cnt_nxt;
  logic [15:0] psc_nxt;
  logic [31:0] ccer_nxt;
  logic [7:0] dir_nxt;
  logic sel_evt;
  logic sel_dir;
  logic sel_ccer;
  logic sel_cnt;
  logic sel_psc;
  logic sel_arr;
  logic sel_cap;
  logic [1:0] cap_idx;

  tcb_ch_if ch [NCH] ();
  tcb_psc_if prescaler_value ();

  function automatic logic [31:0] zext_cnt(input logic [CNT_W-1:0] v);
    logic [31:0] r;
    r = '0;
    r[CNT_W-1:0] = v;
    return r;
  endfunction : zext_cnt

  function automatic tcb_pkg::tcb_dir_e dir_of(input logic [7:0] d, input int unsigned i);
    return tcb_pkg::tcb_dir_e'(d[i*tcb_pkg::DIR_STRIDE +: 2]);
  endfunction : dir_of

  // Enable or polarity bit of channel i inside the enable/polarity word
  function automatic logic ch_bit(input logic [31:0] w, input int unsigned i,
                                  input int unsigned pos);
    return w[i*tcb_pkg::CCER_STRIDE + pos];
  endfunction : ch_bit

  assign adr = {ADR_I[7:2], 2'b00};
  assign req = CYC_I && STB_I && !ack_r;
  assign wr = req && WE_I;

  // One select per register word, one shared by the four capture words; the first matching offset is taken
  always_comb begin
    sel_evt = 1'b0;
    sel_dir = 1'b0;
    sel_ccer = 1'b0;
    sel_cnt = 1'b0;
    sel_psc = 1'b0;
    sel_arr = 1'b0;
    sel_cap = 1'b0;
    cap_idx = 2'(adr[7:2] - tcb_pkg::OFS_CAP0[7:2]);
    if (adr == tcb_pkg::OFS_EVT) begin
      sel_evt = 1'b1;
    end else if (adr == tcb_pkg::OFS_DIR) begin
      sel_dir = 1'b1;
    end else if (adr == tcb_pkg::OFS_CCER) begin
      sel_ccer = 1'b1;
    end else if (adr == tcb_pkg::OFS_CNT) begin
      sel_cnt = 1'b1;
    end else if (adr == tcb_pkg::OFS_PSC) begin
      sel_psc = 1'b1;
    end else if (adr == tcb_pkg::OFS_ARR) begin
      sel_arr = 1'b1;
    end else if (adr >= tcb_pkg::OFS_CAP0 && adr <= tcb_pkg::OFS_CAP3) begin
      sel_cap = 1'b1;
    end
  end

  // One-cycle answer: ack in the cycle after the request is seen, then drop
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // Read data is latched at the taking edge and held until the next read
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      dat_r <= 32'h0000_0000;
    end else if (req && !WE_I) begin
      dat_r <= rd_data;
    end
  end

  // Unmapped offsets still answer, reading zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (sel_ccer) begin
      rd_data = ccer_r;
    end else if (sel_dir) begin
      rd_data = {24'h00_0000, dir_r};
    end else if (sel_cnt) begin
      rd_data = zext_cnt(cnt_r);
    end else if (sel_psc) begin
      rd_data = {16'h0000, psc_r};
    end else if (sel_arr) begin
      rd_data = arr_r;
    end else if (sel_cap) begin
      rd_data = zext_cnt(cap_r[cap_idx]);
    end
  end

  assign ccer_nxt = tcb_pkg::tcb_merge(ccer_r, DAT_I, SEL_I) & tcb_pkg::CCER_MASK;

  // Reserved bits are masked so they always read back zero
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ccer_r <= tcb_pkg::CCER_RST;
    end else if (wr && sel_ccer) begin
      ccer_r <= ccer_nxt;
    end
  end

  // A channel that is switched on keeps its field, the others take the write
  always_comb begin
    dir_nxt = dir_r;
    for (int i = 0; i < NCH; i++) begin
      if (!ch_bit(ccer_r, i, tcb_pkg::CCER_EN_BIT)) begin
        dir_nxt[i*tcb_pkg::DIR_STRIDE +: 2] = DAT_I[i*tcb_pkg::DIR_STRIDE +: 2];
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      dir_r <= tcb_pkg::DIR_RST;
    end else if (wr && sel_dir && SEL_I[0]) begin
      dir_r <= dir_nxt;
    end
  end

  // Only the low half is storage; the upper half of the word reads zero
  assign psc_nxt = 16'(tcb_pkg::tcb_merge({16'h0000, psc_r}, DAT_I, SEL_I));

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      psc_r <= tcb_pkg::PSC_RST;
    end else if (wr && sel_psc) begin
      psc_r <= psc_nxt;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      arr_r <= tcb_pkg::ARR_RST;
    end else if (wr && sel_arr) begin
      arr_r <= tcb_pkg::tcb_merge(arr_r, DAT_I, SEL_I);
    end
  end

  assign ug_hit = wr && sel_evt && SEL_I[0] && DAT_I[tcb_pkg::EVT_UG_BIT];
  assign sw_clear = ug_hit || TRIG_RESET;
  assign run = arr_r != 32'h0000_0000;
  assign ovf = run && prescaler_value.tick && zext_cnt(cnt_r) >= arr_r;
  assign upd = sw_clear || ovf;

  assign prescaler_value.preload = psc_r;
  assign prescaler_value.update = upd;

  tcb_prescaler u_psc (
    .clk (REF_CLK),
    .rst (RST),
    .prescaler_value (prescaler_value.core)
  );

  assign cnt_wide = tcb_pkg::tcb_merge(zext_cnt(cnt_r), DAT_I, SEL_I);

  // Software clear beats a bus write, which beats the running count
  always_comb begin
    cnt_nxt = cnt_r;
    if (sw_clear) begin
      cnt_nxt = '0;
    end else if (wr && sel_cnt) begin
      cnt_nxt = cnt_wide[CNT_W-1:0];
    end else if (ovf) begin
      cnt_nxt = '0;
    end else if (run && prescaler_value.tick) begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cnt_r <= CNT_W'(tcb_pkg::CNT_RST);
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      upd_r <= 1'b0;
    end else begin
      upd_r <= upd;
    end
  end

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    localparam logic [7:0] CAP_OFS = 8'(tcb_pkg::OFS_CAP0 + 8'(i * 4));
    logic [31:0] cap_wide;
    tcb_pkg::tcb_dir_e dsel;

    assign dsel = dir_of(dir_r, i);
    assign ch[i].ref_sig = CH_REF[i];
    assign ch[i].pol = ch_bit(ccer_r, i, tcb_pkg::CCER_POL_BIT);
    assign ch[i].en = ch_bit(ccer_r, i, tcb_pkg::CCER_EN_BIT);
    assign ch[i].is_input = dsel != tcb_pkg::TCB_DIR_OUT;
    // Raw selection ahead of the synchroniser; a glitch on a mode change is harmless
    assign ch[i].pin_raw = (dsel == tcb_pkg::TCB_DIR_IN_PAIR) ? CH_IN[i ^ 1] :
                           (dsel == tcb_pkg::TCB_DIR_IN_TRC) ? TRC_IN : CH_IN[i];

    tcb_channel u_ch (
      .clk (REF_CLK),
      .rst (RST),
      .ch (ch[i].chan)
    );

    assign cap_wide = tcb_pkg::tcb_merge(zext_cnt(cap_r[i]), DAT_I, SEL_I);

    // A capture wins over a software write in the same cycle
    always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
        cap_r[i] <= CNT_W'(tcb_pkg::CAP_RST);
      end else if (ch[i].cap_stb) begin
        cap_r[i] <= cnt_r;
      end else if (wr && adr == CAP_OFS && !ch[i].is_input) begin
        cap_r[i] <= cap_wide[CNT_W-1:0];
      end
    end

    assign CH_OUT[i] = ch[i].ch_out;
    assign CH_OE[i] = ch[i].ch_oe;
    assign CH_TRIG[i] = ch[i].trig;
  end

  assign ACK_O = ack_r;
  assign DAT_O = dat_r;
  assign UPDATE_EVT = upd_r;
endmodule : tcb_timer
`default_nettype wire

// file: verilog/tcb_pkg.sv
`default_nettype none
package tcb_pkg;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned PSC_W = 16;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned ADR_W = 8;

  // Byte offsets of the register words
  localparam logic [7:0] OFS_EVT = 8'h14;
  localparam logic [7:0] OFS_DIR = 8'h18;
  localparam logic [7:0] OFS_CCER = 8'h20;
  localparam logic [7:0] OFS_CNT = 8'h24;
  localparam logic [7:0] OFS_PSC = 8'h28;
  localparam logic [7:0] OFS_ARR = 8'h2C;
  localparam logic [7:0] OFS_CAP0 = 8'h34;
  localparam logic [7:0] OFS_CAP3 = 8'h40;

  // Field positions
  localparam int unsigned EVT_UG_BIT = 0;
  localparam int unsigned CCER_EN_BIT = 0;
  localparam int unsigned CCER_POL_BIT = 1;
  localparam int unsigned CCER_STRIDE = 4;
  localparam int unsigned DIR_STRIDE = 2;
  localparam logic [31:0] CCER_MASK = 32'h0000_3333;

  // Reset values
  localparam logic [31:0] CCER_RST = 32'h0000_0000;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] PSC_RST = 16'h0000;
  localparam logic [31:0] ARR_RST = 32'h0000_0000;
  localparam logic [15:0] CAP_RST = 16'h0000;

  typedef enum logic [1:0] {
    TCB_DIR_OUT = 2'b00,
    TCB_DIR_IN_OWN = 2'b01,
    TCB_DIR_IN_PAIR = 2'b10,
    TCB_DIR_IN_TRC = 2'b11
  } tcb_dir_e;

  // Byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] tcb_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : tcb_merge
endpackage : tcb_pkg
`default_nettype wire

// file: verilog/tcb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tcb_ch_if;
  logic ref_sig;
  logic pol;
  logic en;
  logic is_input;
  logic pin_raw;
  logic ch_out;
  logic ch_oe;
  logic cap_stb;
  logic trig;
  modport chan (input ref_sig, pol, en, is_input, pin_raw,
                output ch_out, ch_oe, cap_stb, trig);
  modport ctl (output ref_sig, pol, en, is_input, pin_raw,
               input ch_out, ch_oe, cap_stb, trig);
endinterface : tcb_ch_if

interface tcb_psc_if;
  logic [tcb_pkg::PSC_W-1:0] preload;
  logic update;
  logic tick;
  modport core (input preload, update, output tick);
  modport ctl (output preload, update, input tick);
endinterface : tcb_psc_if
`default_nettype wire

// file: verilog/tcb_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module tcb_prescaler (
  input wire logic clk,
  input wire logic rst,
  tcb_psc_if.core prescaler_value
);
  logic [tcb_pkg::PSC_W-1:0] active_r;
  logic [tcb_pkg::PSC_W-1:0] div_r;

  // Preload only reaches the divider on an update event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_r <= tcb_pkg::PSC_RST;
    end else if (prescaler_value.update) begin
      active_r <= prescaler_value.preload;
    end
  end

  // Tick is decoded from the divider, so an update on a tick cycle loses no clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= tcb_pkg::PSC_RST;
    end else if (prescaler_value.update) begin
      div_r <= '0;
    end else if (div_r >= active_r) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  assign prescaler_value.tick = div_r >= active_r;
endmodule : tcb_prescaler
`default_nettype wire

// file: verilog/tcb_channel.sv
`timescale 1ns/1ps
`default_nettype none
module tcb_channel (
  input wire logic clk,
  input wire logic rst,
  tcb_ch_if.chan ch
);
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic out_r;
  logic oe_r;
  logic cap_r;
  logic trig_r;
  logic cond;
  logic edge_hit;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= ch.pin_raw;
      sync2_r <= sync1_r;
    end
  end

  assign cond = sync2_r ^ ch.pol;
  // Edges are judged on the pin itself, so a polarity write alone never captures
  assign edge_hit = ch.pol ? (prev_r && !sync2_r) : (sync2_r && !prev_r);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_r <= 1'b0;
      trig_r <= 1'b0;
      cap_r <= 1'b0;
    end else begin
      prev_r <= sync2_r;
      trig_r <= cond;
      cap_r <= ch.is_input && ch.en && edge_hit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (!ch.is_input && ch.en) begin
      out_r <= ch.ref_sig ^ ch.pol;
      oe_r <= 1'b1;
    end else begin
      out_r <= 1'b0;
      oe_r <= 1'b0;
    end
  end

  assign ch.ch_out = out_r;
  assign ch.ch_oe = oe_r;
  assign ch.cap_stb = cap_r;
  assign ch.trig = trig_r;
endmodule : tcb_channel
`default_nettype wire

// file: bench/tcb_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tcb_timer_sva #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [tcb_pkg::ADR_W-1:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire logic [3:0] CH_REF,
  input wire logic [3:0] CH_OUT,
  input wire logic [3:0] CH_OE,
  input wire logic TRIG_RESET,
  input wire logic UPDATE_EVT
);
  logic req;
  logic wr;
  assign req = CYC_I && STB_I && !ACK_O;
  assign wr = CYC_I && STB_I && WE_I;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  property p_ack_resp; req |=> ACK_O; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("missing ack");
  property p_ack_once; ACK_O |=> !ACK_O; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_idle; !(CYC_I && STB_I) |=> !ACK_O; endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("stray ack");
  property p_off_zero; (CH_OUT & ~CH_OE) == 4'h0; endproperty
  a_off_zero: assert property (p_off_zero) else $error("output while off");
  // Bus writes can move enable or polarity, so only quiet cycles are judged
  property p_ref_follow;
    CH_OE[0] && !wr && !$past(wr) && $changed(CH_REF[0]) |=> $changed(CH_OUT[0]);
  endproperty
  a_ref_follow: assert property (p_ref_follow) else $error("out ignores ref");
  property p_ug_upd;
    req && WE_I && ADR_I[7:2] == 6'h05 && SEL_I[0] && DAT_I[0] |-> ##[1:2] UPDATE_EVT;
  endproperty
  a_ug_upd: assert property (p_ug_upd) else $error("no update on ug");
  property p_trig_upd; TRIG_RESET |-> ##[1:2] UPDATE_EVT; endproperty
  a_trig_upd: assert property (p_trig_upd) else $error("no update on trig");
  property p_rsv_zero;
    req && !WE_I && ADR_I[7:2] == 6'h08 |=> (DAT_O & ~32'h0000_3333) == 32'h0000_0000;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit set");
  property p_cnt_rsv;
    req && !WE_I && (ADR_I[7:2] == 6'h09 || ADR_I[7:2] == 6'h0A) |=> DAT_O[31:16] == 16'h0000;
  endproperty
  a_cnt_rsv: assert property (p_cnt_rsv) else $error("upper half set");
endmodule : tcb_timer_sva
bind tcb_timer tcb_timer_sva #(.CNT_W(CNT_W)) u_sva (.REF_CLK(REF_CLK), .RST(RST),
  .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .DAT_I(DAT_I), .SEL_I(SEL_I),
  .DAT_O(DAT_O), .ACK_O(ACK_O), .CH_REF(CH_REF), .CH_OUT(CH_OUT), .CH_OE(CH_OE),
  .TRIG_RESET(TRIG_RESET), .UPDATE_EVT(UPDATE_EVT));
`default_nettype wire

// file: bench/tcb_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcb_pin_model (
  input wire logic [3:0] ch_out,
  input wire logic [3:0] ch_oe,
  input wire logic [3:0] ext_drv,
  input wire logic [3:0] ext_en,
  output logic [3:0] pin
);
  // Undriven pads fall to the pull-down, never keep the last level
  assign pin = (ch_oe & ch_out) | (~ch_oe & ext_en & ext_drv);
endmodule : tcb_pin_model
`default_nettype wire

// file: bench/tcb_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
module tcb_timer_test;
  logic clk = 0;
  logic rst = 1;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic trst = 0;
  logic trc = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [3:0] sel = 4'hF;
  logic [3:0] ref_s = 4'h0;
  logic [3:0] drv = 4'h0;
  logic [3:0] den = 4'h1;
  logic [31:0] rdat, v, c0, w;
  logic ack, upd;
  logic [3:0] out, oe, trg, pin;
  logic [7:0] ofs [5] = '{8'h00, 8'h20, 8'h24, 8'h28, 8'h2C};
  int bad_count = 0;
  int samples_checked = 0;
  int n;
  always #12.5 clk = ~clk;
  tcb_timer i_dut (.REF_CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .DAT_I(dat), .SEL_I(sel), .DAT_O(rdat), .ACK_O(ack), .CH_REF(ref_s),
    .CH_IN(pin), .TRC_IN(trc), .TRIG_RESET(trst), .CH_OUT(out), .CH_OE(oe),
    .CH_TRIG(trg), .UPDATE_EVT(upd));
  tcb_pin_model i_pins (.ch_out(out), .ch_oe(oe), .ext_drv(drv), .ext_en(den), .pin(pin));
  task report_and_stop;
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task wb(input logic w_en, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w_en;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1 && ++t < 50);
    if (t >= 50) bad_count++;
    v = rdat;
    cyc <= 0;
    stb <= 0;
  endtask : wb
  // Counter sampled before the pin edge bounds the captured value
  task hit(input logic lvl);
    wb(0, 8'h24, 0);
    c0 = v;
    drv[0] <= lvl;
    repeat (8) @(posedge clk);
    wb(0, 8'h34, 0);
  endtask : hit
  task per(output int k);
    int t;
    t = 0;
    k = 0;
    while (upd !== 1 && t++ < 99) @(posedge clk);
    do begin
      @(posedge clk);
      k++;
    end while (upd !== 1 && k < 99);
  endtask : per
  initial begin
    #2000000;
    bad_count++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    foreach (ofs[i]) begin
      wb(0, ofs[i], 0);
      chk(v, 0);
    end
    wb(1, 8'h20, 32'h0000_3333);
    wb(0, 8'h20, 0);
    chk(v, 32'h0000_3333);
    for (int i = 0; i < 4; i++) begin
      for (int p = 0; p < 2; p++) begin
        wb(1, 8'h20, (32'h1 | p << 1) << 4 * i);
        ref_s <= 4'h1 << i;
        repeat (3) @(posedge clk);
        chk(oe, 4'h1 << i);
        chk(pin, p ? 4'h0 : 4'h1 << i);
        ref_s <= 4'h0;
        repeat (3) @(posedge clk);
        chk(pin, p ? 4'h1 << i : 4'h0);
      end
      wb(1, 8'h20, 32'h2 << 4 * i);
      repeat (3) @(posedge clk);
      chk({oe, pin}, 0);
    end
    wb(1, 8'h2C, 32'h0000_FFFF);
    wb(1, 8'h20, 32'h0000_0001);
    wb(1, 8'h18, 32'h0000_0001);
    wb(0, 8'h18, 0);
    chk(v, 0);
    wb(1, 8'h20, 0);
    wb(1, 8'h18, 32'h0000_0001);
    wb(0, 8'h18, 0);
    chk(v, 1);
    wb(1, 8'h20, 32'h0000_0001);
    wb(1, 8'h14, 32'h0000_0001);
    hit(1);
    chk(v > c0 && v < c0 + 20, 1);
    chk(trg[0], 1);
    w = v;
    hit(0);
    chk(v, w);
    wb(1, 8'h34, 32'h0000_1234);
    wb(0, 8'h34, 0);
    chk(v, w);
    wb(1, 8'h20, 32'h0000_0003);
    hit(1);
    chk(v, w);
    chk(trg[0], 0);
    hit(0);
    chk(v > c0 && v < c0 + 20, 1);
    w = v;
    wb(1, 8'h20, 32'h0000_0002);
    hit(1);
    hit(0);
    chk(v, w);
    // Neighbour pin feeds channel 2, the trigger input feeds channel 3
    wb(1, 8'h18, 32'h0000_0039);
    wb(1, 8'h20, 32'h0000_0112);
    wb(0, 8'h24, 0);
    c0 = v;
    drv[0] <= 1;
    trc <= 1;
    repeat (8) @(posedge clk);
    wb(0, 8'h38, 0);
    chk(v > c0 && v < c0 + 20, 1);
    chk(trg[2], 1);
    wb(1, 8'h2C, 32'h0000_0002);
    wb(1, 8'h28, 32'h0000_0003);
    wb(1, 8'h14, 32'h0000_0001);
    per(n);
    chk(n, 12);
    wb(1, 8'h28, 32'h0000_0001);
    per(n);
    per(n);
    chk(n, 6);
    wb(1, 8'h2C, 32'h0000_FFFF);
    wb(1, 8'h28, 32'h0000_0003);
    wb(1, 8'h14, 32'h0000_0001);
    wb(1, 8'h28, 32'h0000_0000);
    wb(0, 8'h24, 0);
    c0 = v;
    repeat (40) @(posedge clk);
    wb(0, 8'h24, 0);
    chk(v - c0 > 8 && v - c0 < 13, 1);
    wb(1, 8'h2C, 0);
    wb(1, 8'h24, 32'h0000_0005);
    repeat (20) @(posedge clk);
    wb(0, 8'h24, 0);
    chk(v, 5);
    trst <= 1;
    @(posedge clk);
    trst <= 0;
    wb(0, 8'h24, 0);
    chk(v, 0);
    report_and_stop;
  end
endmodule : tcb_timer_test
`default_nettype wire
